/* File: hw/eqm_defines.vh */
`ifndef EQM_DEFINES_VH
`define EQM_DEFINES_VH

// Register indices; the byte address on the bus is four times the index
`define EQM_IDX_TAP4     12'h41E
`define EQM_IDX_TAP5     12'h420
`define EQM_IDX_TAP6     12'h423
`define EQM_IDX_TAP7     12'h425
`define EQM_IDX_CTRL     12'h410
`define EQM_IDX_STAT     12'h411

// Reset values
`define EQM_RST_SIDE     16'h0000
`define EQM_RST_CTR      24'h000000
`define EQM_RST_CTRL     16'h0000

// Field positions
`define EQM_SIDE_MSB     11
`define EQM_CTR_MSB      17
`define EQM_MODE_MSB     1
`define EQM_MODE_LSB     0
`define EQM_SCW_MSB      4
`define EQM_SCW_LSB      2
`define EQM_LINK_BIT     8

// Mode encodings and weight limit
`define EQM_MODE_BYPASS  2'h0
`define EQM_MODE_ON      2'h2
`define EQM_SCW_MAX      3'h6

// Filter shape
`define EQM_NTAPS        9
`define EQM_CTR_IDX      4
`define EQM_SIDE_W       12
`define EQM_CTR_W        18
`define EQM_FRAC         16

`endif

/* File: hw/eqm_dly.v */
`timescale 1ns/100ps

module eqm_dly #(
   parameter W     = 12,
   parameter DEPTH = 9
) (
   input  wire               clk_sys,  // System clock
   input  wire               rst_n,    // Async reset, active low
   input  wire               en,       // Shift one sample in
   input  wire [W-1:0]       din,      // Newest sample
   output wire [W*DEPTH-1:0] taps      // Slot k holds the sample k steps old
);

   reg [W-1:0] stage_q [0:DEPTH-1];

   genvar k;
   generate
      for (k = 0; k < DEPTH; k = k + 1) begin : g_stage
         always @(posedge clk_sys or negedge rst_n) begin
            if (!rst_n) begin
               stage_q[k] <= {W{1'b0}};
            end else if (en) begin
               stage_q[k] <= (k == 0) ? din : stage_q[(k == 0) ? 0 : k - 1];
            end
         end
         assign taps[k*W +: W] = stage_q[k];
      end
   endgenerate

endmodule

/* File: hw/eqm_sat.v */
`timescale 1ns/100ps

module eqm_sat #(
   parameter IN_W  = 36,
   parameter OUT_W = 12,
   parameter FRAC  = 16
) (
   input  wire [IN_W-1:0]  acc,   // Signed sum with FRAC fraction bits
   output reg  [OUT_W-1:0] y      // Rounded, saturated sample
);

   localparam [IN_W-1:0] HALF  = {{(IN_W-1){1'b0}}, 1'b1} << (FRAC - 1);
   localparam [IN_W-1:0] MAXV  = {{(IN_W-OUT_W+1){1'b0}}, {(OUT_W-1){1'b1}}};
   localparam [IN_W-1:0] MINV  = ~MAXV;

   reg [IN_W-1:0] rnd;
   reg [IN_W-1:0] shr;

   always @* begin
      rnd = acc + HALF;
      shr = $unsigned($signed(rnd) >>> FRAC);
      // Clip instead of wrapping so a hot coefficient set distorts gently
      if ($signed(shr) > $signed(MAXV)) begin
         y = MAXV[OUT_W-1:0];
      end else if ($signed(shr) < $signed(MINV)) begin
         y = MINV[OUT_W-1:0];
      end else begin
         y = shr[OUT_W-1:0];
      end
   end

endmodule

/* File: hw/eqm_taps_mid.v */
// Function
// - Tap four holds a 12-bit signed coefficient in bits 11:0, 15:12 reserved.
// - Tap five is the centre tap, 18-bit signed in bits 17:0, 23:18 reserved.
// - Tap six holds a 12-bit signed coefficient in bits 11:0, upper bits reserved.
// - Tap seven holds a 12-bit signed coefficient in bits 11:0, 15:12 reserved.
// - Dual mode: taps drive channel A only; single mode: the one shared filter.
// - Mode field 0 bypasses, 2 enables; 1 and 3 are reserved.
// - Weight 0..6 scales side coefficients to an LSB of 2^(weight-16).
`timescale 1ns/100ps
`include "eqm_defines.vh"

module eqm_taps_mid #(
   parameter SAMP_W = 12,
   parameter ACC_W  = 36
) (
   input  wire              clk_sys,            // System clock, 125 MHz
   input  wire              rst_n,              // Async reset, active low
   input  wire [13:0]       avs_address,        // Byte address
   input  wire              avs_read,           // Read request
   input  wire              avs_write,          // Write request
   input  wire [31:0]       avs_writedata,      // Write data
   input  wire [3:0]        avs_byteenable,     // Byte lanes
   output wire [31:0]       avs_readdata,       // Read data
   output wire              avs_waitrequest,    // Stall request
   input  wire              chan_dual,          // 1 dual channel, 0 single channel
   input  wire [11:0]       tap_one_coeff,      // First tap from neighbour logic
   input  wire [11:0]       tap_two_coeff,      // Second tap
   input  wire [11:0]       tap_three_coeff,    // Third tap
   input  wire [11:0]       tap_eight_coeff,    // Eighth tap
   input  wire [11:0]       tap_nine_coeff,     // Ninth tap
   output wire              serial_link_enable, // Serial output link enable
   input  wire              samp_in_valid,      // Input sample strobe
   input  wire [SAMP_W-1:0] samp_a_in,          // Channel A or single stream
   input  wire [SAMP_W-1:0] samp_b_in,          // Channel B stream
   output wire              samp_out_valid,     // Output sample strobe
   output wire [SAMP_W-1:0] samp_a_out,         // Equalized A or single stream
   output wire [SAMP_W-1:0] samp_b_out          // Aligned B, zero in single mode
);

   localparam NT  = `EQM_NTAPS;
   localparam CW  = `EQM_CTR_W;
   localparam SW  = `EQM_SIDE_W;
   localparam PW  = CW + SAMP_W;

   function eqm_hit;
      input [13:0] addr;
      input [11:0] idx;
      begin
         eqm_hit = (addr[13:2] == idx);
      end
   endfunction

   function [31:0] eqm_merge;
      input [31:0] old;
      input [31:0] wd;
      input [3:0]  be;
      integer b;
      begin
         eqm_merge = old;
         for (b = 0; b < 4; b = b + 1) begin
            if (be[b]) begin
               eqm_merge[b*8 +: 8] = wd[b*8 +: 8];
            end
         end
      end
   endfunction

   // Register file
   reg  [15:0] tap_four_coeff_q;
   reg  [23:0] tap_five_center_coeff_q;
   reg  [15:0] tap_six_coeff_q;
   reg  [15:0] tap_seven_coeff_q;
   reg  [15:0] ctrl_q;
   reg  [31:0] rdata_q;
   reg         ack_q;
   reg  [31:0] cur_word;
   wire [31:0] wmerge;
   wire        req;
   wire        wr_go;
   wire [1:0]  equalizer_mode_sel;
   wire [2:0]  side_coeff_weight;
   wire [2:0]  scw_eff;
   wire        eq_on;
   wire [31:0] stat_word;

   assign req             = avs_read | avs_write;
   // One wait cycle: the first request cycle is stalled, the second is taken
   assign avs_waitrequest = req & ~ack_q;
   assign wr_go           = ack_q & avs_write;
   assign avs_readdata    = rdata_q;

   assign equalizer_mode_sel = ctrl_q[`EQM_MODE_MSB:`EQM_MODE_LSB];
   assign side_coeff_weight  = ctrl_q[`EQM_SCW_MSB:`EQM_SCW_LSB];
   assign serial_link_enable = ctrl_q[`EQM_LINK_BIT];

   assign eq_on = (equalizer_mode_sel == `EQM_MODE_ON);
   // weight limit; settings above six are held at six
   assign scw_eff = (side_coeff_weight > `EQM_SCW_MAX) ? `EQM_SCW_MAX : side_coeff_weight;

   assign stat_word = {26'h0000000, scw_eff, eq_on, serial_link_enable, chan_dual};

   always @* begin
      cur_word = 32'h00000000;
      if (eqm_hit(avs_address, `EQM_IDX_TAP4)) begin
         cur_word = {16'h0000, tap_four_coeff_q};
      end else if (eqm_hit(avs_address, `EQM_IDX_TAP5)) begin
         cur_word = {8'h00, tap_five_center_coeff_q};
      end else if (eqm_hit(avs_address, `EQM_IDX_TAP6)) begin
         cur_word = {16'h0000, tap_six_coeff_q};
      end else if (eqm_hit(avs_address, `EQM_IDX_TAP7)) begin
         cur_word = {16'h0000, tap_seven_coeff_q};
      end else if (eqm_hit(avs_address, `EQM_IDX_CTRL)) begin
         cur_word = {16'h0000, ctrl_q};
      end else if (eqm_hit(avs_address, `EQM_IDX_STAT)) begin
         cur_word = stat_word;
      end
   end

   assign wmerge = eqm_merge(cur_word, avs_writedata, avs_byteenable);

   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         ack_q   <= 1'b0;
         rdata_q <= 32'h00000000;
      end else begin
         ack_q <= req & ~ack_q;
         // Capture early so data already stands when the stall drops
         if (avs_read & ~ack_q) begin
            rdata_q <= cur_word;
         end
      end
   end

   // Reserved bits are kept and read back as written
   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         tap_four_coeff_q        <= `EQM_RST_SIDE;
         tap_five_center_coeff_q <= `EQM_RST_CTR;
         tap_six_coeff_q         <= `EQM_RST_SIDE;
         tap_seven_coeff_q       <= `EQM_RST_SIDE;
         ctrl_q                  <= `EQM_RST_CTRL;
      end else if (wr_go) begin
         if (eqm_hit(avs_address, `EQM_IDX_TAP4)) begin
            tap_four_coeff_q <= wmerge[15:0];
         end
         if (eqm_hit(avs_address, `EQM_IDX_TAP5)) begin
            tap_five_center_coeff_q <= wmerge[23:0];
         end
         if (eqm_hit(avs_address, `EQM_IDX_TAP6)) begin
            tap_six_coeff_q <= wmerge[15:0];
         end
         if (eqm_hit(avs_address, `EQM_IDX_TAP7)) begin
            tap_seven_coeff_q <= wmerge[15:0];
         end
         if (eqm_hit(avs_address, `EQM_IDX_CTRL)) begin
            ctrl_q <= wmerge[15:0];
         end
      end
   end

   // Sample delay lines
   wire [SAMP_W*NT-1:0] xa_flat;
   wire [SAMP_W*5-1:0]  xb_flat;

   eqm_dly #(
      .W     (SAMP_W),
      .DEPTH (NT)
   ) u_dly_a (
      .clk_sys (clk_sys),
      .rst_n   (rst_n),
      .en      (samp_in_valid),
      .din     (samp_a_in),
      .taps    (xa_flat)
   );

   eqm_dly #(
      .W     (SAMP_W),
      .DEPTH (`EQM_CTR_IDX + 1)
   ) u_dly_b (
      .clk_sys (clk_sys),
      .rst_n   (rst_n),
      .en      (samp_in_valid),
      .din     (samp_b_in),
      .taps    (xb_flat)
   );

   // Coefficients widened to the centre width; side taps sign-extended
   wire [CW*NT-1:0] coef_flat;

   assign coef_flat[0*CW +: CW] = {{(CW-SW){tap_one_coeff[SW-1]}}, tap_one_coeff};
   assign coef_flat[1*CW +: CW] = {{(CW-SW){tap_two_coeff[SW-1]}}, tap_two_coeff};
   assign coef_flat[2*CW +: CW] = {{(CW-SW){tap_three_coeff[SW-1]}}, tap_three_coeff};
   assign coef_flat[3*CW +: CW] = {{(CW-SW){tap_four_coeff_q[`EQM_SIDE_MSB]}},
                                   tap_four_coeff_q[`EQM_SIDE_MSB:0]};
   assign coef_flat[4*CW +: CW] = tap_five_center_coeff_q[`EQM_CTR_MSB:0];
   assign coef_flat[5*CW +: CW] = {{(CW-SW){tap_six_coeff_q[`EQM_SIDE_MSB]}},
                                   tap_six_coeff_q[`EQM_SIDE_MSB:0]};
   assign coef_flat[6*CW +: CW] = {{(CW-SW){tap_seven_coeff_q[`EQM_SIDE_MSB]}},
                                   tap_seven_coeff_q[`EQM_SIDE_MSB:0]};
   assign coef_flat[7*CW +: CW] = {{(CW-SW){tap_eight_coeff[SW-1]}}, tap_eight_coeff};
   assign coef_flat[8*CW +: CW] = {{(CW-SW){tap_nine_coeff[SW-1]}}, tap_nine_coeff};

   // Products; coefficients are used live, so the link must be idle
   // while software rewrites them
   wire [ACC_W*NT-1:0] term_flat;

   genvar k;
   generate
      for (k = 0; k < NT; k = k + 1) begin : g_tap
         wire signed [PW-1:0]    raw;
         wire signed [ACC_W-1:0] ext;
         assign raw = $signed(coef_flat[k*CW +: CW]) * $signed(xa_flat[k*SAMP_W +: SAMP_W]);
         assign ext = {{(ACC_W-PW){raw[PW-1]}}, raw};
         if (k == `EQM_CTR_IDX) begin : g_ctr
            assign term_flat[k*ACC_W +: ACC_W] = ext;
         end else begin : g_side
            assign term_flat[k*ACC_W +: ACC_W] = ext <<< scw_eff;
         end
      end
   endgenerate

   reg [ACC_W-1:0] acc_sum;
   integer t;

   always @* begin
      acc_sum = {ACC_W{1'b0}};
      for (t = 0; t < NT; t = t + 1) begin
         acc_sum = acc_sum + term_flat[t*ACC_W +: ACC_W];
      end
   end

   // Pipeline: stage one holds the sum, stage two the output samples
   reg [ACC_W-1:0]  sum_q;
   reg [SAMP_W-1:0] ctr_a_q;
   reg [SAMP_W-1:0] ctr_b_q;
   reg              on_q;
   reg              dual_q;
   reg              v0_q;
   reg              v1_q;
   reg              v2_q;
   reg [SAMP_W-1:0] out_a_q;
   reg [SAMP_W-1:0] out_b_q;
   wire [SAMP_W-1:0] sat_y;

   eqm_sat #(
      .IN_W  (ACC_W),
      .OUT_W (SAMP_W),
      .FRAC  (`EQM_FRAC)
   ) u_sat (
      .acc (sum_q),
      .y   (sat_y)
   );

   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         sum_q   <= {ACC_W{1'b0}};
         ctr_a_q <= {SAMP_W{1'b0}};
         ctr_b_q <= {SAMP_W{1'b0}};
         on_q    <= 1'b0;
         dual_q  <= 1'b0;
         v0_q    <= 1'b0;
         v1_q    <= 1'b0;
      end else begin
         // Sum one edge after the shift so the newest sample is in it
         v0_q <= samp_in_valid;
         v1_q <= v0_q;
         if (v0_q) begin
            sum_q <= acc_sum;
            // Bypass taps the centre slot so both paths share one latency
            ctr_a_q <= xa_flat[`EQM_CTR_IDX*SAMP_W +: SAMP_W];
            ctr_b_q <= xb_flat[`EQM_CTR_IDX*SAMP_W +: SAMP_W];
            on_q    <= eq_on;
            dual_q  <= chan_dual;
         end
      end
   end

   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         v2_q    <= 1'b0;
         out_a_q <= {SAMP_W{1'b0}};
         out_b_q <= {SAMP_W{1'b0}};
      end else begin
         v2_q <= v1_q;
         if (v1_q) begin
            out_a_q <= on_q ? sat_y : ctr_a_q;
            // channel B never sees these taps
            out_b_q <= dual_q ? ctr_b_q : {SAMP_W{1'b0}};
         end
      end
   end

   assign samp_out_valid = v2_q;
   assign samp_a_out     = out_a_q;
   assign samp_b_out     = out_b_q;

endmodule

/* File: tb/eqm_taps_mid_monitor.sv */
`timescale 1ns/100ps
`include "eqm_defines.vh"

module eqm_taps_mid_monitor #(
   parameter SAMP_W = 12
) (
   input logic              clk_sys,            // Clock
   input logic              rst_n,              // Reset
   input logic [13:0]       avs_address,        // Byte address
   input logic              avs_read,           // Read
   input logic              avs_write,          // Write
   input logic [31:0]       avs_writedata,      // Write data
   input logic [3:0]        avs_byteenable,     // Lanes
   input logic [31:0]       avs_readdata,       // Read data
   input logic              avs_waitrequest,    // Stall
   input logic              chan_dual,          // Dual mode
   input logic              serial_link_enable, // Link enable
   input logic              samp_in_valid,      // In strobe
   input logic              samp_out_valid,     // Out strobe
   input logic [SAMP_W-1:0] samp_a_out,         // A out
   input logic [SAMP_W-1:0] samp_b_out          // B out
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);

   wire [11:0] idx   = avs_address[13:2];
   wire        acc_r = avs_read & ~avs_waitrequest;
   wire        acc_w = avs_write & ~avs_waitrequest;

   sequence s_req_new;
      (avs_read || avs_write) && avs_waitrequest;
   endsequence
   sequence s_accept;
      (avs_read || avs_write) && !avs_waitrequest;
   endsequence

   a_wait_one_cycle: assert property (s_req_new |=> s_accept)
      else $error("request not accepted after one wait");
   a_wait_idle_low: assert property (!(avs_read || avs_write) |-> !avs_waitrequest)
      else $error("stall raised without request");
   a_side_tap_width: assert property (acc_r && (idx == `EQM_IDX_TAP4 ||
      idx == `EQM_IDX_TAP6 || idx == `EQM_IDX_TAP7) |-> avs_readdata[31:16] == 16'h0000)
      else $error("side tap reads above bit 15");
   a_centre_tap_width: assert property (acc_r && idx == `EQM_IDX_TAP5
      |-> avs_readdata[31:24] == 8'h00) else $error("centre tap reads above bit 23");
   // Guard keeps a reset in mid-flight from being taken for a lost sample
   a_out_latency: assert property ($past(rst_n, 3) && $past(rst_n, 2) && $past(rst_n)
      |-> samp_out_valid == $past(samp_in_valid, 3)) else $error("output strobe latency");
   a_b_zero_single: assert property (samp_out_valid && !$past(chan_dual, 2)
      |-> samp_b_out == '0) else $error("channel B not zero in single mode");
   a_out_hold_idle: assert property (!samp_out_valid
      |-> $stable(samp_a_out) && $stable(samp_b_out)) else $error("output moved without strobe");
   a_link_only_write: assert property (!acc_w |=> $stable(serial_link_enable))
      else $error("link enable changed without write");
   a_link_follows_write: assert property (acc_w && idx == `EQM_IDX_CTRL && avs_byteenable[1]
      |=> serial_link_enable == $past(avs_writedata[8])) else $error("link enable not written");
endmodule

bind eqm_taps_mid eqm_taps_mid_monitor #(.SAMP_W(SAMP_W)) u_mon (.clk_sys, .rst_n,
   .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata,
   .avs_waitrequest, .chan_dual, .serial_link_enable, .samp_in_valid, .samp_out_valid,
   .samp_a_out, .samp_b_out);

/* File: tb/testbench.sv */
`timescale 1ns/100ps
`include "eqm_defines.vh"

module testbench;
   logic        clk_sys         = 1'b0;
   logic        rst_n           = 1'b0;
   logic [13:0] avs_address     = 14'h0000;
   logic        avs_read        = 1'b0;
   logic        avs_write       = 1'b0;
   logic [31:0] avs_writedata   = 32'h0;
   logic [3:0]  avs_byteenable  = 4'hF;
   logic        chan_dual       = 1'b1;
   logic [11:0] tap_one_coeff   = 12'h010;
   logic [11:0] tap_two_coeff   = 12'hFF0;
   logic [11:0] tap_three_coeff = 12'h020;
   logic [11:0] tap_eight_coeff = 12'h7FF;
   logic [11:0] tap_nine_coeff  = 12'h800;
   logic        samp_in_valid   = 1'b0;
   logic [11:0] samp_a_in       = 12'h000;
   logic [11:0] samp_b_in       = 12'h000;
   wire  [31:0] avs_readdata;
   wire         avs_waitrequest;
   wire         serial_link_enable;
   wire         samp_out_valid;
   wire  [11:0] samp_a_out;
   wire  [11:0] samp_b_out;
   int          failures  = 0;
   int          tests_run = 0;
   int          ha[9];
   int          hb[9];
   int          cf[9]     = '{16, -16, 32, -128, 65536, 256, 2047, 2047, -2048};
   logic [31:0] rd;

   always #4 clk_sys = ~clk_sys;

   eqm_taps_mid u_dut (.clk_sys, .rst_n, .avs_address, .avs_read, .avs_write, .avs_writedata,
      .avs_byteenable, .avs_readdata, .avs_waitrequest, .chan_dual, .tap_one_coeff,
      .tap_two_coeff, .tap_three_coeff, .tap_eight_coeff, .tap_nine_coeff,
      .serial_link_enable, .samp_in_valid, .samp_a_in, .samp_b_in, .samp_out_valid,
      .samp_a_out, .samp_b_out);

   task give_verdict;
      $display("Counts: %0d compares, %0d mismatches", tests_run, failures);
      if (failures == 0 && tests_run > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   task chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         failures++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask

   task tmo(input int n, input int lim);
      if (n >= lim) begin
         failures++;
         $display("[FAIL] %0t wait ran out", $time);
         give_verdict;
      end
   endtask

   // Request is held until the edge that samples the stall low
   task bus(input logic wr, input logic [11:0] idx, input logic [31:0] d, input logic [3:0] be);
      int n;
      @(posedge clk_sys);
      avs_write <= wr;
      avs_read <= ~wr;
      avs_address <= {idx, 2'b00};
      avs_writedata <= d;
      avs_byteenable <= be;
      n = 0;
      do begin
         @(posedge clk_sys);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 16);
      tmo(n, 16);
      rd = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
   endtask

   task rdchk(input logic [11:0] idx, input logic [31:0] exp);
      bus(1'b0, idx, 32'h0, 4'hF);
      chk(rd, exp);
   endtask

   // Outputs are judged at the falling edge, well clear of the update edge
   task samp(input int a, input int b);
      int n;
      for (int k = 8; k > 0; k--) begin
         ha[k] = ha[k-1];
         hb[k] = hb[k-1];
      end
      ha[0] = a;
      hb[0] = b;
      @(posedge clk_sys);
      samp_in_valid <= 1'b1;
      samp_a_in <= a[11:0];
      samp_b_in <= b[11:0];
      @(posedge clk_sys);
      samp_in_valid <= 1'b0;
      n = 0;
      do begin
         @(negedge clk_sys);
         n++;
      end while (samp_out_valid !== 1'b1 && n < 8);
      tmo(n, 8);
   endtask

   function automatic logic [11:0] model(input logic [1:0] m, input logic [2:0] w);
      longint acc;
      acc = 0;
      if (m != 2'h2)
         return ha[4][11:0];
      for (int k = 0; k < 9; k++)
         acc += (k == 4) ? longint'(cf[4]) * ha[4] : (longint'(cf[k]) * ha[k]) <<< ((w == 7) ? 6 : w);
      acc = (acc + 32768) >>> 16;
      if (acc > 2047) acc = 2047;
      if (acc < -2048) acc = -2048;
      return acc[11:0];
   endfunction

   task t_reset;
      rdchk(`EQM_IDX_TAP4, 32'h0);
      rdchk(`EQM_IDX_TAP5, 32'h0);
      rdchk(`EQM_IDX_TAP6, 32'h0);
      rdchk(`EQM_IDX_TAP7, 32'h0);
      rdchk(`EQM_IDX_CTRL, 32'h0);
      chk({31'h0, serial_link_enable}, 32'h0);
      $display("test reset values done");
   endtask

   task t_regs;
      bus(1'b1, `EQM_IDX_TAP4, 32'hFFFFAF80, 4'hF);
      rdchk(`EQM_IDX_TAP4, 32'h0000AF80);
      bus(1'b1, `EQM_IDX_TAP5, 32'hFFFFFFFF, 4'hF);
      rdchk(`EQM_IDX_TAP5, 32'h00FFFFFF);
      bus(1'b1, `EQM_IDX_TAP5, 32'hFFC10000, 4'h6);
      rdchk(`EQM_IDX_TAP5, 32'h00C100FF);
      bus(1'b1, `EQM_IDX_TAP5, 32'h0, 4'h1);
      rdchk(`EQM_IDX_TAP5, 32'h00C10000);
      bus(1'b1, `EQM_IDX_TAP6, 32'hFFFF3100, 4'hF);
      rdchk(`EQM_IDX_TAP6, 32'h00003100);
      bus(1'b1, `EQM_IDX_TAP7, 32'h000007FF, 4'hF);
      rdchk(`EQM_IDX_TAP7, 32'h000007FF);
      bus(1'b1, 12'h7FF, 32'hFFFFFFFF, 4'hF);
      rdchk(12'h7FF, 32'h0);
      bus(1'b1, `EQM_IDX_CTRL, 32'h100, 4'hF);
      @(negedge clk_sys);
      chk({31'h0, serial_link_enable}, 32'h1);
      bus(1'b1, `EQM_IDX_CTRL, 32'h0, 4'hF);
      @(negedge clk_sys);
      chk({31'h0, serial_link_enable}, 32'h0);
      $display("test register access done");
   endtask

   // Dual settings come first so the B delay line never straddles a mode change
   task t_filt;
      logic [5:0] cfg[7];
      logic [1:0] m;
      logic [2:0] w;
      cfg = '{6'h20, 6'h2D, 6'h22, 6'h3A, 6'h0E, 6'h1F, 6'h1E};
      for (int i = 0; i < 7; i++) begin
         m = cfg[i][1:0];
         w = cfg[i][4:2];
         @(posedge clk_sys);
         chan_dual <= cfg[i][5];
         bus(1'b1, `EQM_IDX_CTRL, {27'h0, cfg[i][4:0]}, 4'hF);
         rdchk(`EQM_IDX_STAT, {26'h0, (w == 3'h7) ? 3'h6 : w, m == 2'h2, 1'b0, cfg[i][5]});
         for (int j = 0; j < 10; j++) begin
            samp(((j * 523 + i * 211) % 4096) - 2048, ((j * 301 + 7) % 4096) - 2048);
            chk({20'h0, samp_a_out}, {20'h0, model(m, w)});
            chk({20'h0, samp_b_out}, cfg[i][5] ? {20'h0, hb[4][11:0]} : 32'h0);
         end
      end
      $display("test filter modes done");
   endtask

   initial begin
      repeat (16) @(posedge clk_sys);
      rst_n <= 1'b1;
      t_reset;
      t_regs;
      t_filt;
      give_verdict;
   end
endmodule
